/* File: core/drl_link.sv */
// drl_link: drive-side status, clocking and serial data link.
// assumes all pins synchronous to mclk; wishbone classic slave on mclk.
`timescale 1ns/100ps
module drl_link (
  input wire logic mclk, // system clock, 50 MHz
  input wire logic sys_rst, // synchronous reset, high
  // wishbone classic slave
  input wire logic wb_cyc_i, // bus cycle
  input wire logic wb_stb_i, // strobe
  input wire logic wb_we_i, // write enable
  input wire logic [3:0] wb_adr_i, // byte address
  input wire logic [3:0] wb_sel_i, // byte lanes
  input wire logic [31:0] wb_dat_i, // write data
  output logic [31:0] wb_dat_o, // read data
  output logic wb_ack_o, // acknowledge
  // servo track side
  input wire logic servo_tribit, // one pulse per servo tribit
  input wire logic servo_sector, // sector mark from servo track
  input wire logic servo_index, // index from servo track
  input wire logic on_cyl, // positioner on cylinder
  input wire logic seek_err, // seek error latched
  input wire logic ext_fault, // other fault conditions
  // addressing from tag decode
  input wire logic cyl_strobe, // cylinder address tag
  input wire logic offset_req, // servo offset plus or minus
  input wire logic head0_sel, // moving head zero addressed
  input wire logic fixed_sel, // fixed head track addressed
  input wire logic unit_tag, // unit select tag
  input wire logic [3:0] unit_lines, // unit number lines
  input wire logic write_gate, // write gate control
  input wire logic read_gate, // read gate control
  input wire logic fault_clear, // fault clear pulse
  // serial data link
  input wire logic wr_clk_in, // write clock from controller
  input wire logic wr_data_in, // NRZ write data
  input wire logic medium_rd, // raw read bit from chain
  output logic servo_clk, // servo clock out
  output logic rd_clk, // read clock out
  output logic rd_data, // NRZ read data
  output logic medium_wr, // bit to write driver
  output logic medium_wr_en, // write driver enable
  // status to controller
  output logic wprot, // write protected
  output logic fault, // fault
  output logic busy, // dual port busy
  output logic seek_end, // seek end
  output logic unit_sel, // unit selected
  output logic sector, // sector mark
  output logic index // index mark
);

  // ------------------------------------------------------------------
  // register file
  // ------------------------------------------------------------------
  logic [7:0] ctrl_r;
  logic [31:0] rdat_nxt;
  logic ack_r;
  logic fault_r;
  logic [1:0] fsrc_r;
  logic sel_r;
  logic rd_locked_r;
  logic wr_ok;
  logic hold_busy;
  logic prot_hit;
  logic [3:0] unit_num;
  drl_pkg::drl_prot_type prot_mode;

  assign unit_num = ctrl_r[drl_pkg::CTRL_UNIT_LSB +: 4];
  assign prot_mode = drl_pkg::drl_prot_type'(ctrl_r[drl_pkg::CTRL_PROT_LSB +: 2]);

  // one ack per request, dropped the cycle after
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= wb_cyc_i & wb_stb_i & ~ack_r;
    end
  end

  // control register write, low byte lane only
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      ctrl_r <= drl_pkg::CTRL_RST;
    end else if (wb_cyc_i && wb_stb_i && wb_we_i && !ack_r &&
                 wb_adr_i == drl_pkg::ADDR_CTRL && wb_sel_i[0]) begin
      ctrl_r <= wb_dat_i[7:0];
    end
  end

  // read mux, unmapped reads zero
  always_comb begin
    rdat_nxt = 32'h0000_0000;
    case (wb_adr_i)
      drl_pkg::ADDR_CTRL: begin
        rdat_nxt[7:0] = ctrl_r;
      end
      drl_pkg::ADDR_STATUS: begin
        rdat_nxt[drl_pkg::ST_SEL] = sel_r;
        rdat_nxt[drl_pkg::ST_FAULT] = fault_r;
        rdat_nxt[drl_pkg::ST_SEEK_END] = seek_end;
        rdat_nxt[drl_pkg::ST_WPROT] = wprot;
        rdat_nxt[drl_pkg::ST_RD_LOCK] = rd_locked_r;
        rdat_nxt[drl_pkg::ST_WR_EN] = medium_wr_en;
        rdat_nxt[drl_pkg::ST_HOLD] = hold_busy;
      end
      drl_pkg::ADDR_FAULT: begin
        rdat_nxt[1:0] = fsrc_r;
      end
      default: begin
        rdat_nxt = 32'h0000_0000;
      end
    endcase
  end

  // read data register
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (wb_cyc_i && wb_stb_i && !wb_we_i && !ack_r) begin
      wb_dat_o <= rdat_nxt;
    end
  end

  assign wb_ack_o = ack_r;

  // ------------------------------------------------------------------
  // unit selection and write protect
  // ------------------------------------------------------------------
  logic unit_tag_d;

  // latch compare on unit tag leading edge
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      unit_tag_d <= 1'b0;
      sel_r <= 1'b0;
    end else begin
      unit_tag_d <= unit_tag;
      if (unit_tag && !unit_tag_d) begin
        sel_r <= (unit_lines == unit_num);
      end
    end
  end

  // protected region decode
  always_comb begin
    case (prot_mode)
      drl_pkg::PROT_HEAD0: prot_hit = head0_sel & ~fixed_sel;
      drl_pkg::PROT_FIXED: prot_hit = fixed_sel;
      drl_pkg::PROT_ALL: prot_hit = 1'b1;
      default: prot_hit = 1'b0;
    endcase
  end

  // ------------------------------------------------------------------
  // fault latch
  // ------------------------------------------------------------------
  logic prot_viol;
  logic fault_cause;

  assign prot_viol = sel_r & prot_hit & write_gate;
  assign fault_cause = prot_viol | ext_fault;

  // set wins over clear; clear needs cause gone
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      fault_r <= 1'b0;
      fsrc_r <= 2'b00;
    end else if (fault_cause) begin
      fault_r <= 1'b1;
      fsrc_r[drl_pkg::FS_PROT] <= fsrc_r[drl_pkg::FS_PROT] | prot_viol;
      fsrc_r[drl_pkg::FS_EXT] <= fsrc_r[drl_pkg::FS_EXT] | ext_fault;
    end else if (fault_clear) begin
      fault_r <= 1'b0;
      fsrc_r <= 2'b00;
    end
  end

  // ------------------------------------------------------------------
  // seek end
  // ------------------------------------------------------------------
  logic cyl_strobe_d;
  logic offset_d;
  logic hold_start;

  // edges of tag 1 and offset request
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      cyl_strobe_d <= 1'b0;
      offset_d <= 1'b0;
    end else begin
      cyl_strobe_d <= cyl_strobe;
      offset_d <= offset_req;
    end
  end

  assign hold_start = (cyl_strobe & ~cyl_strobe_d) | (offset_req & ~offset_d);

  // minimum clear time after tag 1 or offset
  drl_timer u_hold (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .start(hold_start),
    .load(drl_pkg::SEEK_HOLD_CYC),
    .busy(hold_busy)
  );

  // ------------------------------------------------------------------
  // clocks
  // ------------------------------------------------------------------
  logic tribit_d;
  logic servo_clk_w;
  logic rd_clk_w;
  logic rd_rise;
  logic wr_clk_w;
  logic wr_rise;
  logic rd_gate_d;
  logic medium_rd_d;
  logic wr_clk_d;
  logic rd_resync;
  logic [11:0] lock_cnt_r;

  // tribit edge detector
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      tribit_d <= 1'b0;
    end else begin
      tribit_d <= servo_tribit;
    end
  end

  // servo clock locked to tribits, free running
  drl_nco u_servo (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .inc(drl_pkg::SERVO_INC),
    .resync(servo_tribit & ~tribit_d),
    .clk_out(servo_clk_w),
    .rise()
  );

  // read edge and gate edge history
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      rd_gate_d <= 1'b0;
      medium_rd_d <= 1'b0;
      wr_clk_d <= 1'b0;
    end else begin
      rd_gate_d <= read_gate;
      medium_rd_d <= medium_rd;
      wr_clk_d <= wr_clk_in;
    end
  end

  // realign on gate rise and on data transitions while gated
  assign rd_resync = (read_gate & ~rd_gate_d) | (read_gate & (medium_rd ^ medium_rd_d));

  // read clock runs continuously
  drl_nco u_read (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .inc(drl_pkg::SERVO_INC),
    .resync(rd_resync),
    .clk_out(rd_clk_w),
    .rise(rd_rise)
  );

  // lock window count after read gate rises
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      lock_cnt_r <= 12'h000;
      rd_locked_r <= 1'b0;
    end else if (!read_gate || !rd_gate_d) begin
      lock_cnt_r <= 12'h000;
      rd_locked_r <= 1'b0;
    end else if (lock_cnt_r == drl_pkg::RD_LOCK_CYC - 12'h001) begin
      rd_locked_r <= 1'b1;
    end else begin
      lock_cnt_r <= lock_cnt_r + 12'h001;
    end
  end

  // write clock relocked on controller clock edges
  drl_nco u_write (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .inc(drl_pkg::SERVO_INC),
    .resync(wr_clk_in & ~wr_clk_d),
    .clk_out(wr_clk_w),
    .rise(wr_rise)
  );

  // ------------------------------------------------------------------
  // data paths
  // ------------------------------------------------------------------
  // write allowed only when selected, clean and on cylinder
  assign wr_ok = write_gate & sel_r & ~fault_r & ~fault_cause & on_cyl & ~seek_err;

  // nrz write bit retimed by relocked write clock
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      medium_wr <= 1'b0;
      medium_wr_en <= 1'b0;
    end else begin
      medium_wr_en <= wr_ok;
      if (wr_rise) begin
        medium_wr <= wr_data_in & wr_ok;
      end
    end
  end

  // nrz read bit at read clock rise, held low until locked
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      rd_data <= 1'b0;
    end else if (rd_rise) begin
      rd_data <= medium_rd & rd_locked_r & sel_r;
    end
  end

  // ------------------------------------------------------------------
  // status outputs
  // ------------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      servo_clk <= 1'b0;
      rd_clk <= 1'b0;
      wprot <= 1'b0;
      fault <= 1'b0;
      busy <= 1'b0;
      seek_end <= 1'b0;
      unit_sel <= 1'b0;
      sector <= 1'b0;
      index <= 1'b0;
    end else begin
      servo_clk <= servo_clk_w;
      rd_clk <= rd_clk_w;
      wprot <= sel_r & prot_hit;
      fault <= fault_r;
      busy <= 1'b0;
      seek_end <= (on_cyl | seek_err) & ~hold_busy;
      unit_sel <= sel_r;
      sector <= servo_sector;
      index <= servo_index;
    end
  end

endmodule : drl_link

/* File: core/drl_nco.sv */
// drl_nco: phase accumulator clock with phase realignment.
// assumes resync is a one-cycle pulse from the caller's edge detector.
`timescale 1ns/100ps
module drl_nco (
  input wire logic mclk, // system clock
  input wire logic sys_rst, // synchronous reset, high
  input wire logic [31:0] inc, // phase step per cycle
  input wire logic resync, // realign phase to mid-cell
  output logic clk_out, // recovered clock level
  output logic rise // one-cycle pulse at clock rise
);

  logic [31:0] acc_r;
  logic [31:0] acc_nxt;

  // advance or realign the phase
  always_comb begin
    acc_nxt = resync ? drl_pkg::PHASE_MID : acc_r + inc;
  end

  // phase register
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      acc_r <= 32'h0000_0000;
    end else begin
      acc_r <= acc_nxt;
    end
  end

  // clock level and rising edge marker
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      clk_out <= 1'b0;
      rise <= 1'b0;
    end else begin
      clk_out <= acc_nxt[31];
      rise <= acc_nxt[31] & ~clk_out;
    end
  end

endmodule : drl_nco

/* File: core/drl_pkg.sv */
// drl_pkg: constants shared by the drive-side data link block.
// assumes a single 50 MHz system clock and synchronous pin inputs.
package drl_pkg;

  // ------------------------------------------------------------------
  // clocking and timing
  // ------------------------------------------------------------------
  localparam longint CLK_HZ = 50_000_000;
  localparam longint CLK_PERIOD_PS = 20_000;
  localparam longint SERVO_HZ = 7_970_000;
  // phase increment of a 32-bit accumulator, servo rate over system rate
  localparam logic [31:0] SERVO_INC = 32'((SERVO_HZ * (64'h1 << 32)) / CLK_HZ);
  localparam logic [31:0] PHASE_MID = 32'h8000_0000;
  // read clock phase sync deadline after read gate rises (longest: round down)
  localparam longint RD_LOCK_NS = 7_000;
  localparam logic [11:0] RD_LOCK_CYC = 12'((RD_LOCK_NS * 1000) / CLK_PERIOD_PS);
  // seek end cleared this long after tag 1 or servo offset (least: round up)
  localparam longint SEEK_HOLD_NS = 30_000;
  localparam logic [11:0] SEEK_HOLD_CYC =
    12'((SEEK_HOLD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);

  // ------------------------------------------------------------------
  // register map (byte addresses, one word each)
  // ------------------------------------------------------------------
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h4;
  localparam logic [3:0] ADDR_FAULT = 4'h8;
  localparam logic [7:0] CTRL_RST = 8'h00;
  // ctrl fields
  localparam int CTRL_UNIT_LSB = 0;
  localparam int CTRL_PROT_LSB = 4;
  // status fields
  localparam int ST_SEL = 0;
  localparam int ST_FAULT = 1;
  localparam int ST_SEEK_END = 2;
  localparam int ST_WPROT = 3;
  localparam int ST_RD_LOCK = 4;
  localparam int ST_WR_EN = 5;
  localparam int ST_HOLD = 6;
  // fault source fields
  localparam int FS_PROT = 0;
  localparam int FS_EXT = 1;

  // write protect mode
  typedef enum logic [1:0] {
    PROT_NONE  = 2'b00,
    PROT_HEAD0 = 2'b01,
    PROT_FIXED = 2'b10,
    PROT_ALL   = 2'b11
  } drl_prot_type;

endpackage : drl_pkg

/* File: core/drl_timer.sv */
// drl_timer: down counter, reloads on start, busy while non-zero.
// assumes load value is at least one cycle.
`timescale 1ns/100ps
module drl_timer (
  input wire logic mclk, // system clock
  input wire logic sys_rst, // synchronous reset, high
  input wire logic start, // restart count
  input wire logic [11:0] load, // count in cycles
  output logic busy // high while counting
);

  logic [11:0] cnt_r;

  // count down to zero, restart wins
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      cnt_r <= 12'h000;
    end else if (start) begin
      cnt_r <= load;
    end else if (cnt_r != 12'h000) begin
      cnt_r <= cnt_r - 12'h001;
    end
  end

  assign busy = (cnt_r != 12'h000);

endmodule : drl_timer

/* File: testbench/drl_ctl_model.sv */
// drl_ctl_model: controller end of the serial write link.
// assumes servo clock is sampled on mclk; write gate comes from the bench.
`timescale 1ns/100ps
module drl_ctl_model (
  input wire logic mclk, // system clock
  input wire logic servo_clk, // servo clock from drive
  input wire logic write_gate, // write gate from bench
  output logic wr_clk_in, // returned write clock
  output logic wr_data_in // nrz write data
);
  logic clk_q;
  int bit_cnt;
  // one sector image, repeated while write gate stays up
  function automatic logic fmt_bit(input int b);
    int p;
    p = b % 400;
    if (p < 112) return 1'b0;
    if (p < 120) return p == 119;
    if (p < 168) return 1'b1; // address and checkword, ones here
    if (p < 232) return 1'b0;
    if (p < 240) return p == 239;
    if (p < 384) return 1'b1;
    return 1'b0;
  endfunction : fmt_bit
  initial begin
    wr_clk_in = 1'b0;
    wr_data_in = 1'b0;
  end
  // write clock returned continuously, one cycle behind
  always @(posedge mclk) wr_clk_in <= servo_clk;
  // new format bit per servo fall
  always @(posedge mclk) begin
    clk_q <= servo_clk;
    if (!write_gate) begin
      bit_cnt <= 0;
      wr_data_in <= 1'b0;
    end else if (clk_q && !servo_clk) begin
      bit_cnt <= bit_cnt + 1;
      wr_data_in <= fmt_bit(bit_cnt);
    end
  end
endmodule : drl_ctl_model

/* File: testbench/drl_link_properties.sv */
// drl_link_chk: concurrent checks on the drive link ports.
// assumes it is bound into drl_link and sees only that module's ports.
`timescale 1ns/100ps
module drl_link_chk (
  input wire logic mclk, // clock
  input wire logic sys_rst, // reset
  input wire logic wb_cyc_i, // bus cycle
  input wire logic wb_stb_i, // strobe
  input wire logic wb_we_i, // write
  input wire logic [3:0] wb_adr_i, // address
  input wire logic [3:0] wb_sel_i, // lanes
  input wire logic [31:0] wb_dat_i, // write data
  input wire logic wb_ack_o, // ack
  input wire logic servo_sector, // sector in
  input wire logic servo_index, // index in
  input wire logic on_cyl, // on cylinder
  input wire logic seek_err, // seek error
  input wire logic cyl_strobe, // cylinder tag
  input wire logic offset_req, // offset
  input wire logic head0_sel, // head 0 region
  input wire logic fixed_sel, // fixed region
  input wire logic unit_tag, // unit tag
  input wire logic [3:0] unit_lines, // unit lines
  input wire logic write_gate, // write gate
  input wire logic fault_clear, // fault clear
  input wire logic servo_clk, // servo clock
  input wire logic medium_wr_en, // write enable
  input wire logic wprot, // protected
  input wire logic fault, // fault
  input wire logic busy, // busy
  input wire logic seek_end, // seek end
  input wire logic unit_sel, // selected
  input wire logic sector, // sector out
  input wire logic index // index out
);
  logic [3:0] unit_r;
  logic [1:0] prot_r;
  logic [11:0] seek_cnt_r;
  logic region;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  // --------------------------------------------------------------------
  // helper logic
  // --------------------------------------------------------------------
  // ctrl shadow, taken at the same edge as the slave takes it
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      unit_r <= 4'h0;
      prot_r <= 2'h0;
    end else if (wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0]
                 && wb_adr_i == drl_pkg::ADDR_CTRL) begin
      unit_r <= wb_dat_i[3:0];
      prot_r <= wb_dat_i[5:4];
    end
  end
  // cycles since last seek tag or offset rise, saturating
  always_ff @(posedge mclk) begin
    if (sys_rst) seek_cnt_r <= 12'h000;
    else if ($rose(cyl_strobe) || $rose(offset_req)) seek_cnt_r <= 12'h001;
    else if (seek_cnt_r != 12'h000 && seek_cnt_r != 12'hfff) seek_cnt_r <= seek_cnt_r + 12'h001;
  end
  // addressed region protected under the current mode
  assign region = prot_r == 2'h3 || (prot_r == 2'h1 && head0_sel) || (prot_r == 2'h2 && fixed_sel);

  // --------------------------------------------------------------------
  // properties
  // --------------------------------------------------------------------
  sequence s_prot_write;
    write_gate && wprot ##1 write_gate && wprot;
  endsequence
  property p_busy; busy == 1'b0; endproperty
  property p_wprot; $stable(unit_sel) |-> wprot == (unit_sel && $past(region)); endproperty
  property p_fault_set; s_prot_write |-> ##[1:3] fault; endproperty
  property p_fault_hold; fault && !fault_clear && !$past(fault_clear) |=> fault; endproperty
  property p_wr_inhibit; fault || !$past(write_gate) |-> !medium_wr_en; endproperty
  property p_seek_follow;
    !$past(sys_rst) && (seek_cnt_r == 12'h000 || seek_cnt_r > 12'h5e1)
      && $past(on_cyl || seek_err) |-> seek_end;
  endproperty
  property p_seek_clear; seek_cnt_r >= 12'h003 && seek_cnt_r <= 12'h5dc |-> !seek_end; endproperty
  property p_unit; $rose(unit_tag) |-> ##2 unit_sel == $past(unit_lines == unit_r, 2); endproperty
  property p_marks;
    !$past(sys_rst) |-> sector == $past(servo_sector) && index == $past(servo_index);
  endproperty
  property p_servo_run; !$past(sys_rst) ##0 $stable(servo_clk)[*6] |-> 1'b0; endproperty
  a_busy: assert property (p_busy) else $error("busy raised");
  a_wprot: assert property (p_wprot) else $error("wprot wrong");
  a_fault_set: assert property (p_fault_set) else $error("no fault");
  a_fault_hold: assert property (p_fault_hold) else $error("fault dropped");
  a_wr_inhibit: assert property (p_wr_inhibit) else $error("write enabled");
  a_seek_follow: assert property (p_seek_follow) else $error("seek end low");
  a_seek_clear: assert property (p_seek_clear) else $error("seek end high");
  a_unit: assert property (p_unit) else $error("unit select wrong");
  a_marks: assert property (p_marks) else $error("marks not passed");
  a_servo_run: assert property (p_servo_run) else $error("servo clock stuck");
endmodule : drl_link_chk

bind drl_link drl_link_chk u_chk (
  .mclk(mclk), .sys_rst(sys_rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_ack_o(wb_ack_o), .servo_sector(servo_sector), .servo_index(servo_index),
  .on_cyl(on_cyl), .seek_err(seek_err), .cyl_strobe(cyl_strobe), .offset_req(offset_req),
  .head0_sel(head0_sel), .fixed_sel(fixed_sel), .unit_tag(unit_tag), .unit_lines(unit_lines),
  .write_gate(write_gate), .fault_clear(fault_clear), .servo_clk(servo_clk),
  .medium_wr_en(medium_wr_en), .wprot(wprot), .fault(fault), .busy(busy),
  .seek_end(seek_end), .unit_sel(unit_sel), .sector(sector), .index(index)
);

/* File: testbench/drl_link_tb_top.sv */
// drl_link_tb_top: directed bench for the drive-side link block.
// assumes drl_pkg, drl_link, the checker and the controller model compiled first.
`timescale 1ns/100ps
module drl_link_tb_top;
  logic mclk, sys_rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, servo_tribit, servo_sector;
  logic servo_index, on_cyl, seek_err, ext_fault, cyl_strobe, offset_req, head0_sel;
  logic fixed_sel, unit_tag, write_gate, read_gate, fault_clear, wr_clk_in, wr_data_in;
  logic medium_rd, servo_clk, rd_clk, rd_data, medium_wr, medium_wr_en, wprot, fault;
  logic busy, seek_end, unit_sel, sector, index;
  logic [3:0] wb_adr_i, wb_sel_i, unit_lines;
  logic [31:0] wb_dat_i, wb_dat_o, rd_w;
  int err_count, checked;

  drl_link dut (
    .mclk(mclk), .sys_rst(sys_rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .servo_tribit(servo_tribit),
    .servo_sector(servo_sector), .servo_index(servo_index), .on_cyl(on_cyl),
    .seek_err(seek_err), .ext_fault(ext_fault), .cyl_strobe(cyl_strobe),
    .offset_req(offset_req), .head0_sel(head0_sel), .fixed_sel(fixed_sel),
    .unit_tag(unit_tag), .unit_lines(unit_lines), .write_gate(write_gate),
    .read_gate(read_gate), .fault_clear(fault_clear), .wr_clk_in(wr_clk_in),
    .wr_data_in(wr_data_in), .medium_rd(medium_rd), .servo_clk(servo_clk), .rd_clk(rd_clk),
    .rd_data(rd_data), .medium_wr(medium_wr), .medium_wr_en(medium_wr_en), .wprot(wprot),
    .fault(fault), .busy(busy), .seek_end(seek_end), .unit_sel(unit_sel), .sector(sector),
    .index(index)
  );
  drl_ctl_model ctl (
    .mclk(mclk), .servo_clk(servo_clk), .write_gate(write_gate), .wr_clk_in(wr_clk_in),
    .wr_data_in(wr_data_in)
  );

  // --------------------------------------------------------------------
  // tasks
  // --------------------------------------------------------------------
  // compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // let n edges pass, then settle
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : tick
  // one classic wishbone cycle, held until ack
  task automatic wb_io(input logic we, input logic [3:0] adr, input logic [31:0] wd,
                       output logic [31:0] rd);
    int n;
    @(posedge mclk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= wd;
    wb_sel_i <= 4'hf;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    rd = wb_dat_o;
    if (n >= 50) err_count++;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask : wb_io
  // unit number 5 with the given protect mode
  task automatic set_ctrl(input logic [1:0] m);
    wb_io(1'b1, drl_pkg::ADDR_CTRL, {26'h0, m, 4'h5}, rd_w);
  endtask : set_ctrl
  // unit select tag pulse with unit lines
  task automatic tag_unit(input logic [3:0] n);
    @(posedge mclk);
    unit_lines <= n;
    unit_tag <= 1'b1;
    @(posedge mclk);
    unit_tag <= 1'b0;
    tick(3);
  endtask : tag_unit
  // one-cycle fault clear pulse
  task automatic clear_fault;
    @(posedge mclk);
    fault_clear <= 1'b1;
    @(posedge mclk);
    fault_clear <= 1'b0;
    tick(4);
  endtask : clear_fault
  // counts, verdict, stop
  task automatic end_of_test;
    $display("checked %0d err_count %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : end_of_test

  // --------------------------------------------------------------------
  // clock, watchdog, tests
  // --------------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  initial begin
    repeat (20000) @(posedge mclk);
    err_count++;
    end_of_test();
  end
  initial begin
    int m, r, n;
    logic prev, rprev;
    sys_rst = 1'b1;
    {wb_cyc_i, wb_stb_i, wb_we_i, servo_tribit, servo_sector, servo_index, on_cyl} = '0;
    {seek_err, ext_fault, cyl_strobe, offset_req, head0_sel, fixed_sel, unit_tag} = '0;
    {write_gate, read_gate, fault_clear, medium_rd} = '0;
    {wb_adr_i, wb_sel_i, unit_lines, wb_dat_i} = '0;
    repeat (12) @(posedge mclk);
    sys_rst <= 1'b0;
    on_cyl <= 1'b1;
    wb_io(1'b0, drl_pkg::ADDR_CTRL, 32'h0, rd_w);
    chk(rd_w, {24'h0, drl_pkg::CTRL_RST});
    wb_io(1'b1, 4'hc, 32'hffff_ffff, rd_w);
    wb_io(1'b0, 4'hc, 32'h0, rd_w);
    chk(rd_w, 32'h0);
    set_ctrl(2'h0);
    tag_unit(4'h3);
    chk(unit_sel, 1'b0);
    tag_unit(4'h5);
    chk(unit_sel, 1'b1);
    wb_io(1'b0, drl_pkg::ADDR_STATUS, 32'h0, rd_w);
    chk(rd_w[drl_pkg::ST_SEL], 1'b1);
    chk(busy, 1'b0);
    for (m = 0; m < 4; m++) begin
      for (r = 0; r < 3; r++) begin
        set_ctrl(2'(m));
        @(posedge mclk);
        head0_sel <= (r == 1);
        fixed_sel <= (r == 2);
        tick(3);
        chk(wprot, m == 3 || (m == r && r != 0));
      end
    end
    set_ctrl(2'h1);
    @(posedge mclk);
    head0_sel <= 1'b1;
    fixed_sel <= 1'b0;
    write_gate <= 1'b1;
    tick(4);
    chk(fault, 1'b1);
    chk(medium_wr_en, 1'b0);
    clear_fault();
    chk(fault, 1'b1);
    @(posedge mclk);
    write_gate <= 1'b0;
    tick(4);
    chk(fault, 1'b1);
    wb_io(1'b0, drl_pkg::ADDR_FAULT, 32'h0, rd_w);
    chk(rd_w[drl_pkg::FS_PROT], 1'b1);
    clear_fault();
    chk(fault, 1'b0);
    set_ctrl(2'h0);
    @(posedge mclk);
    head0_sel <= 1'b0;
    tick(250);
    @(posedge mclk);
    write_gate <= 1'b1;
    tick(4);
    chk(medium_wr_en, 1'b1);
    tick(300);
    chk(medium_wr, 1'b0);
    tick(700);
    chk(medium_wr, 1'b1);
    @(posedge mclk);
    write_gate <= 1'b0;
    medium_rd <= 1'b1;
    tick(20);
    @(posedge mclk);
    servo_sector <= 1'b1;
    @(posedge mclk);
    servo_sector <= 1'b0;
    read_gate <= 1'b1;
    tick(100);
    chk(rd_data, 1'b0);
    tick(300);
    chk(rd_data, 1'b1);
    @(posedge mclk);
    read_gate <= 1'b0;
    for (m = 0; m < 2; m++) begin
      tick(2);
      chk(seek_end, 1'b1);
      @(posedge mclk);
      cyl_strobe <= (m == 0);
      offset_req <= (m == 1);
      @(posedge mclk);
      cyl_strobe <= 1'b0;
      offset_req <= 1'b0;
      tick(1400);
      chk(seek_end, 1'b0);
      tick(200);
      chk(seek_end, 1'b1);
    end
    @(posedge mclk);
    on_cyl <= 1'b0;
    seek_err <= 1'b1;
    tick(3);
    chk(seek_end, 1'b1);
    @(posedge mclk);
    seek_err <= 1'b0;
    tick(3);
    chk(seek_end, 1'b0);
    tag_unit(4'h2);
    @(posedge mclk);
    servo_sector <= 1'b1;
    servo_index <= 1'b1;
    tick(1);
    chk({sector, index, unit_sel}, 3'b110);
    @(posedge mclk);
    servo_sector <= 1'b0;
    servo_index <= 1'b0;
    n = 0;
    r = 0;
    prev = servo_clk;
    rprev = rd_clk;
    for (m = 0; m < 1000; m++) begin
      @(posedge mclk);
      if (servo_clk && !prev) n++;
      if (rd_clk && !rprev) r++;
      prev = servo_clk;
      rprev = rd_clk;
    end
    chk(n >= 158 && n <= 161, 1'b1);
    chk(r >= 158 && r <= 161, 1'b1);
    end_of_test();
  end
endmodule : drl_link_tb_top
